// File: hdl/eivu_pkg.sv
// Constants, register map and types of the external interrupt and vector unit.
package eivu_pkg;
    localparam int APB_ADDR_W = 10;
    localparam int APB_DATA_W = 32;
    localparam int REG_IDX_W = 8;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CORE_CTRL = 8'h35;
    localparam logic [7:0] IDX_GEN_MASK = 8'h3B;
    localparam logic [7:0] IDX_GEN_FLAG = 8'h3A;
    localparam logic [7:0] IDX_CHG_MASK_A = 8'h23;
    localparam logic [7:0] IDX_CHG_MASK_B = 8'h22;
    localparam logic [7:0] IDX_WAKE_STAT = 8'h30;
    localparam int SENSE_LO = 0;
    localparam int SENSE_HI = 1;
    localparam int EN_EXT1 = 7;
    localparam int EN_EXT0 = 6;
    localparam int EN_PC_A = 5;
    localparam int EN_PC_B = 4;
    localparam int FLAG_EXT1 = 7;
    localparam int FLAG_EXT0 = 6;
    localparam int FLAG_PC = 5;
    localparam logic [1:0] CORE_CTRL_RST = 2'h0;
    localparam logic [3:0] GEN_MASK_RST = 4'h0;
    localparam logic [7:0] CHG_MASK_A_RST = 8'hC8;
    localparam logic [7:0] CHG_MASK_B_RST = 8'hFF;
    localparam int NUM_WATCH = 16;
    localparam int GRP_B_LO = 8;
    localparam int GRP_B_HI = 11;
    localparam int NUM_SRC = 18;
    localparam int VEC_W = 5;
    localparam logic [4:0] VEC_RESET = 5'h00;
    localparam logic [4:0] VEC_EXT0 = 5'h01;
    localparam logic [4:0] VEC_PC = 5'h02;
    localparam logic [4:0] VEC_EXT1 = 5'h0D;
    localparam logic [4:0] VEC_LAST = 5'h12;
    localparam int CLK_PERIOD_NS = 25;
    localparam int STARTUP_UNIT_NS = 1000;
    localparam int STARTUP_UNIT_CYC = (STARTUP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    typedef enum logic [1:0] {
        EIVU_SENSE_LOW = 2'b00,
        EIVU_SENSE_ANY = 2'b01,
        EIVU_SENSE_FALL = 2'b10,
        EIVU_SENSE_RISE = 2'b11
    } eivu_sense_t;
    typedef enum logic {
        EIVU_RUN = 1'b0,
        EIVU_START = 1'b1
    } eivu_wake_t;
endpackage : eivu_pkg

// File: hdl/eivu_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module eivu_pin_sync #(
    parameter int WIDTH = 18
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinLvl
);
    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
    logic [WIDTH-1:0] s1_next, s2_next, s3_next, lvl_next;

    // Only the second and third stages are compared; the first stage may be metastable.
    always_comb begin
        s1_next = pinIn;
        s2_next = s1_reg;
        s3_next = s2_reg;
        lvl_next = lvl_reg;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                lvl_next[i] = s3_reg[i];
            end
        end
    end

    // Pins idle high after reset so that no spurious change appears.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
            lvl_reg <= '1;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            lvl_reg <= lvl_next;
        end
    end

    assign pinLvl = lvl_reg;
endmodule : eivu_pin_sync
`default_nettype wire

// File: hdl/eivu_prio_enc.sv
// Priority encoder that picks the pending source with the lowest vector address.
`timescale 1ns/1ps
`default_nettype none
module eivu_prio_enc #(
    parameter int NUM = 18
) (
    input wire logic [NUM-1:0] pend,
    output logic [eivu_pkg::VEC_W-1:0] vecIdx,
    output logic anyPend
);
    // Bit i of pend belongs to vector address i + 1; scanning downward lets the lowest win.
    always_comb begin
        vecIdx = eivu_pkg::VEC_RESET;
        anyPend = 1'b0;
        for (int i = NUM - 1; i >= 0; i--) begin
            if (pend[i]) begin
                vecIdx = eivu_pkg::VEC_W'(i + 1);
                anyPend = 1'b1;
            end
        end
    end
endmodule : eivu_prio_enc
`default_nettype wire

// File: hdl/eivu_top.sv
// External interrupt detection, vector selection and wake-up for a small microcontroller.
// Operation
// - Reset vector is word address zero.
// - First external request vectors to 0x0001.
// - Shared pin-change request vectors to 0x0002.
// - Second external request vectors to 0x000D.
// - Other peripheral sources take fixed slots.
// - Vector only for enabled, requesting sources.
// - Requests trigger even when pins drive.
// - Any enabled watched pin toggle requests.
// - Mask registers select contributing change pins.
// - Pin change detection needs no I/O clock.
// - Sense falling, rising or low level.
// - Low level keeps requesting while low.
// - Edge detection only with I/O clock.
// - Low level detected without I/O clock.
// - Level must outlast start-up for interrupt.
// - Early level loss resumes after sleep.
// - Start-up length comes from fuse settings.
// - Sense bits decode low, any, fall, rise.
// - Pins sampled before edge detection.
// - Flags set on trigger, cleared by service.
// - Level sensing holds request flag cleared.
`timescale 1ns/1ps
`default_nettype none
module eivu_top #(
    parameter int STARTUP_CYC = eivu_pkg::STARTUP_UNIT_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [eivu_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [eivu_pkg::APB_DATA_W-1:0] pwdata,
    output logic [eivu_pkg::APB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic extReq0Pin,
    input wire logic extReq1Pin,
    input wire logic [eivu_pkg::NUM_WATCH-1:0] changeWatchPins,
    input wire logic [eivu_pkg::NUM_SRC-1:0] periphReq,
    input wire logic globalEnable,
    input wire logic sleeping,
    input wire logic ioClkRun,
    input wire logic [1:0] startupFuse,
    input wire logic [3:0] clockSourceFuse,
    input wire logic coreAck,
    output logic irqReq,
    output logic [eivu_pkg::VEC_W-1:0] vecAddr,
    output logic wakeUp,
    output logic resumeNext
);
    localparam int SYNC_W = eivu_pkg::NUM_WATCH + 2;

    function automatic eivu_pkg::eivu_sense_t senseOf(input logic [1:0] sel);
        senseOf = eivu_pkg::eivu_sense_t'(sel);
    endfunction : senseOf

    function automatic logic edgeHit(input eivu_pkg::eivu_sense_t mode, input logic prev,
                                     input logic cur);
        case (mode)
            eivu_pkg::EIVU_SENSE_ANY: edgeHit = prev != cur;
            eivu_pkg::EIVU_SENSE_FALL: edgeHit = prev && !cur;
            eivu_pkg::EIVU_SENSE_RISE: edgeHit = !prev && cur;
            default: edgeHit = 1'b0;
        endcase
    endfunction : edgeHit

    // The start-up time grows with the start-up fuse and bits 1:0 of the clock-source fuse; the long settings take many cycles.
    function automatic logic [eivu_pkg::CNT_W-1:0] startupLoad(input logic [1:0] startup_fuse,
                                                              input logic [3:0] clock_source_fuse);
        logic [eivu_pkg::CNT_W-1:0] base;
        base = eivu_pkg::CNT_W'(STARTUP_CYC) * eivu_pkg::CNT_W'({2'h0, startup_fuse} + 4'h1);
        startupLoad = base << clock_source_fuse[1:0];
    endfunction : startupLoad

    // Pins are read as inputs even when their port drives them, so software can provoke requests.
    logic [SYNC_W-1:0] pinLvl;
    eivu_pin_sync #(.WIDTH(SYNC_W)) uSync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pinIn({changeWatchPins, extReq1Pin, extReq0Pin}),
        .pinLvl(pinLvl)
    );

    logic lvl0, lvl1;
    logic [eivu_pkg::NUM_WATCH-1:0] lvlWatch;
    assign lvl0 = pinLvl[0];
    assign lvl1 = pinLvl[1];
    assign lvlWatch = pinLvl[SYNC_W-1:2];

    logic [1:0] coreCtrl_reg, coreCtrl_next;
    logic [3:0] genMask_reg, genMask_next;
    logic [7:0] chgMaskA_reg, chgMaskA_next;
    logic [7:0] chgMaskB_reg, chgMaskB_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic ext0Flag_reg, ext0Flag_next;
    logic ext1Flag_reg, ext1Flag_next;
    logic pcFlag_reg, pcFlag_next;
    logic [1:0] prevExt_reg, prevExt_next;
    logic [eivu_pkg::NUM_WATCH-1:0] prevWatch_reg, prevWatch_next;
    eivu_pkg::eivu_wake_t wake_reg, wake_next;
    logic [eivu_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic wakeUp_reg, wakeUp_next;
    logic resumeNext_reg, resumeNext_next;
    logic irqReq_reg, irqReq_next;
    logic [eivu_pkg::VEC_W-1:0] vecAddr_reg, vecAddr_next;

    logic [eivu_pkg::REG_IDX_W-1:0] regIdx;
    logic wrEn, flagW1c0, flagW1c1, flagW1cPc;
    eivu_pkg::eivu_sense_t senseMode;
    logic edge0, edge1, pcChange;
    logic [eivu_pkg::NUM_WATCH-1:0] watchEn;
    logic en0, en1, pcEn;
    logic [eivu_pkg::NUM_SRC-1:0] pendSrc;
    logic [eivu_pkg::VEC_W-1:0] encIdx;
    logic anyPend, wakeEvent, ackExt0, ackExt1, ackPc;

    assign regIdx = paddr[eivu_pkg::APB_ADDR_W-1:2];
    assign wrEn = psel && penable && pready_reg && pwrite;
    assign senseMode = senseOf(coreCtrl_reg);
    assign en0 = genMask_reg[eivu_pkg::EN_EXT0 - 4];
    assign en1 = genMask_reg[eivu_pkg::EN_EXT1 - 4];
    assign pcEn = genMask_reg[eivu_pkg::EN_PC_A - 4] || genMask_reg[eivu_pkg::EN_PC_B - 4];

    // Register bus: one wait cycle, then data and the error flag stand with pready.
    always_comb begin
        coreCtrl_next = coreCtrl_reg;
        genMask_next = genMask_reg;
        chgMaskA_next = chgMaskA_reg;
        chgMaskB_next = chgMaskB_reg;
        pready_next = psel && penable && !pready_reg;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        if (psel && penable && !pready_reg) begin
            prdata_next = '0;
            case (regIdx)
                eivu_pkg::IDX_CORE_CTRL: prdata_next[1:0] = coreCtrl_reg;
                eivu_pkg::IDX_GEN_MASK: prdata_next[7:4] = genMask_reg;
                eivu_pkg::IDX_GEN_FLAG: prdata_next[7:5] = {ext1Flag_reg, ext0Flag_reg, pcFlag_reg};
                eivu_pkg::IDX_CHG_MASK_A: prdata_next[7:0] = chgMaskA_reg;
                eivu_pkg::IDX_CHG_MASK_B: prdata_next[7:0] = chgMaskB_reg;
                eivu_pkg::IDX_WAKE_STAT: prdata_next[1:0] = {wakeUp_reg, wake_reg};
                default: pslverr_next = 1'b1;
            endcase
        end
        if (wrEn) begin
            case (regIdx)
                eivu_pkg::IDX_CORE_CTRL: coreCtrl_next = pwdata[1:0];
                eivu_pkg::IDX_GEN_MASK: genMask_next = pwdata[7:4];
                eivu_pkg::IDX_CHG_MASK_A: chgMaskA_next = pwdata[7:0];
                eivu_pkg::IDX_CHG_MASK_B: chgMaskB_next = pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            coreCtrl_reg <= eivu_pkg::CORE_CTRL_RST;
            genMask_reg <= eivu_pkg::GEN_MASK_RST;
            chgMaskA_reg <= eivu_pkg::CHG_MASK_A_RST;
            chgMaskB_reg <= eivu_pkg::CHG_MASK_B_RST;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            coreCtrl_reg <= coreCtrl_next;
            genMask_reg <= genMask_next;
            chgMaskA_reg <= chgMaskA_next;
            chgMaskB_reg <= chgMaskB_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Group A enables watched pins 7:0 and 15:12, group B pins 11:8.
    always_comb begin
        for (int i = 0; i < eivu_pkg::NUM_WATCH; i++) begin
            if (i >= eivu_pkg::GRP_B_LO && i <= eivu_pkg::GRP_B_HI) begin
                watchEn[i] = genMask_reg[eivu_pkg::EN_PC_B - 4];
            end else begin
                watchEn[i] = genMask_reg[eivu_pkg::EN_PC_A - 4];
            end
        end
    end

    assign flagW1c0 = wrEn && regIdx == eivu_pkg::IDX_GEN_FLAG && pwdata[eivu_pkg::FLAG_EXT0];
    assign flagW1c1 = wrEn && regIdx == eivu_pkg::IDX_GEN_FLAG && pwdata[eivu_pkg::FLAG_EXT1];
    assign flagW1cPc = wrEn && regIdx == eivu_pkg::IDX_GEN_FLAG && pwdata[eivu_pkg::FLAG_PC];
    assign ackExt0 = coreAck && vecAddr_reg == eivu_pkg::VEC_EXT0;
    assign ackExt1 = coreAck && vecAddr_reg == eivu_pkg::VEC_EXT1;
    assign ackPc = coreAck && vecAddr_reg == eivu_pkg::VEC_PC;

    // Edge history only advances with the I/O clock, so a halted clock sees no edge.
    assign edge0 = ioClkRun && edgeHit(senseMode, prevExt_reg[0], lvl0);
    assign edge1 = ioClkRun && edgeHit(senseMode, prevExt_reg[1], lvl1);
    assign pcChange = |((lvlWatch ^ prevWatch_reg) & {chgMaskB_reg, chgMaskA_reg} & watchEn);

    // Detection and flags; a set in the same cycle as a clear wins.
    always_comb begin
        prevExt_next = ioClkRun ? {lvl1, lvl0} : prevExt_reg;
        prevWatch_next = lvlWatch;
        ext0Flag_next = ext0Flag_reg;
        ext1Flag_next = ext1Flag_reg;
        pcFlag_next = pcFlag_reg;
        if (flagW1c0 || ackExt0) begin
            ext0Flag_next = 1'b0;
        end
        if (flagW1c1 || ackExt1) begin
            ext1Flag_next = 1'b0;
        end
        if (flagW1cPc || ackPc) begin
            pcFlag_next = 1'b0;
        end
        if (edge0) begin
            ext0Flag_next = 1'b1;
        end
        if (edge1) begin
            ext1Flag_next = 1'b1;
        end
        if (pcChange) begin
            pcFlag_next = 1'b1;
        end
        if (senseMode == eivu_pkg::EIVU_SENSE_LOW) begin
            ext0Flag_next = 1'b0;
            ext1Flag_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prevExt_reg <= 2'h3;
            prevWatch_reg <= 16'hFFFF;
            ext0Flag_reg <= 1'b0;
            ext1Flag_reg <= 1'b0;
            pcFlag_reg <= 1'b0;
        end else begin
            prevExt_reg <= prevExt_next;
            prevWatch_reg <= prevWatch_next;
            ext0Flag_reg <= ext0Flag_next;
            ext1Flag_reg <= ext1Flag_next;
            pcFlag_reg <= pcFlag_next;
        end
    end

    // Low level is read straight from the synchronised pin and needs no I/O clock.
    always_comb begin
        pendSrc = periphReq;
        if (senseMode == eivu_pkg::EIVU_SENSE_LOW) begin
            pendSrc[eivu_pkg::VEC_EXT0 - 1] = en0 && !lvl0;
            pendSrc[eivu_pkg::VEC_EXT1 - 1] = en1 && !lvl1;
        end else begin
            pendSrc[eivu_pkg::VEC_EXT0 - 1] = en0 && ext0Flag_reg;
            pendSrc[eivu_pkg::VEC_EXT1 - 1] = en1 && ext1Flag_reg;
        end
        pendSrc[eivu_pkg::VEC_PC - 1] = pcEn && pcFlag_reg;
    end

    eivu_prio_enc #(.NUM(eivu_pkg::NUM_SRC)) uEnc (
        .pend(pendSrc),
        .vecIdx(encIdx),
        .anyPend(anyPend)
    );

    assign wakeEvent = anyPend;

    // Wake-up: the core stays held for the start-up time, then either takes a request or resumes.
    always_comb begin
        wake_next = wake_reg;
        cnt_next = cnt_reg;
        wakeUp_next = wakeUp_reg;
        resumeNext_next = 1'b0;
        case (wake_reg)
            eivu_pkg::EIVU_RUN: begin
                wakeUp_next = 1'b0;
                if (sleeping && wakeEvent) begin
                    wake_next = eivu_pkg::EIVU_START;
                    cnt_next = startupLoad(startupFuse, clockSourceFuse);
                    wakeUp_next = 1'b1;
                end
            end
            eivu_pkg::EIVU_START: begin
                cnt_next = cnt_reg - 1'b1;
                if (cnt_reg <= 1) begin
                    wake_next = eivu_pkg::EIVU_RUN;
                    wakeUp_next = 1'b0;
                    resumeNext_next = !(globalEnable && anyPend);
                end
            end
            default: begin
                wake_next = eivu_pkg::EIVU_RUN;
                wakeUp_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wake_reg <= eivu_pkg::EIVU_RUN;
            cnt_reg <= '0;
            wakeUp_reg <= 1'b0;
            resumeNext_reg <= 1'b0;
        end else begin
            wake_reg <= wake_next;
            cnt_reg <= cnt_next;
            wakeUp_reg <= wakeUp_next;
            resumeNext_reg <= resumeNext_next;
        end
    end

    // The request drops in the acknowledge cycle so a stale vector is never offered twice.
    always_comb begin
        irqReq_next = globalEnable && anyPend && !coreAck && !sleeping
                      && wake_reg == eivu_pkg::EIVU_RUN;
        vecAddr_next = vecAddr_reg;
        if (irqReq_next) begin
            vecAddr_next = encIdx;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqReq_reg <= 1'b0;
            vecAddr_reg <= eivu_pkg::VEC_RESET;
        end else begin
            irqReq_reg <= irqReq_next;
            vecAddr_reg <= vecAddr_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irqReq = irqReq_reg;
    assign vecAddr = vecAddr_reg;
    assign wakeUp = wakeUp_reg;
    assign resumeNext = resumeNext_reg;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence wakeStart_s;
        wake_reg == eivu_pkg::EIVU_RUN && sleeping && wakeEvent;
    endsequence
    sequence heldAwake_s;
        (wake_reg == eivu_pkg::EIVU_START && wakeUp_reg)[*8];
    endsequence

    resetVec_a: assert property ($fell(sys_rst) |-> vecAddr_reg == eivu_pkg::VEC_RESET)
        else $error("Vector is not the reset address after reset.");
    ext0Vec_a: assert property (globalEnable && pendSrc[0] && !coreAck && !sleeping
        && wake_reg == eivu_pkg::EIVU_RUN |=> irqReq_reg && vecAddr_reg == eivu_pkg::VEC_EXT0)
        else $error("First external request not vectored to its slot.");
    pcVec_a: assert property (irqReq_reg && vecAddr_reg == eivu_pkg::VEC_PC
        |-> $past(pendSrc[1]) && !$past(pendSrc[0]))
        else $error("Pin-change vector without a pin-change request.");
    ext1Vec_a: assert property (irqReq_reg && vecAddr_reg == eivu_pkg::VEC_EXT1
        |-> $past(pendSrc[12]) && $past(pendSrc[11:0]) == 12'h000)
        else $error("Second external vector taken out of priority order.");
    noFetch_a: assert property (!globalEnable || !anyPend |=> !irqReq_reg)
        else $error("Request raised with no enabled pending source.");
    levelFlag_a: assert property (senseMode == eivu_pkg::EIVU_SENSE_LOW |=> !ext0Flag_reg)
        else $error("External flag set while level sensing is selected.");
    pcSet_a: assert property (pcChange |=> pcFlag_reg)
        else $error("Enabled pin toggle did not set the pin-change flag.");
    edgeGate_a: assert property (!ioClkRun && !ext0Flag_reg |=> !ext0Flag_reg)
        else $error("Edge recognised while the I/O clock is halted.");
    startupHold_a: assert property (wakeStart_s |=> heldAwake_s)
        else $error("Start-up period ended too early.");
    resume_a: assert property (wake_reg == eivu_pkg::EIVU_START && cnt_reg <= 1
        && !(globalEnable && anyPend) |=> resumeNext_reg && !irqReq_reg)
        else $error("No resume after a lost wake-up level.");
endmodule : eivu_top
`default_nettype wire

// File: bench/eivu_pin_model.sv
// Board-side drivers of the external request and watched pins.
`timescale 1ns/1ps
`default_nettype none
module eivu_pin_model (
    input wire logic sys_clk,
    input wire logic ext0Cmd,
    input wire logic ext1Cmd,
    input wire logic [15:0] chgCmd,
    output logic extReq0Pin,
    output logic extReq1Pin,
    output logic [15:0] changeWatchPins
);
    logic [17:0] pinState_reg = 18'h3FFFF;
    logic [1:0] age_reg = 2'h3;
    // Levels act as the device's own drivers would, so software can provoke requests.
    assign {extReq1Pin, extReq0Pin, changeWatchPins} = pinState_reg;
    always @(posedge sys_clk) begin
        // A new level waits until the old one stood two clocks, so no pulse is too short.
        if ({ext1Cmd, ext0Cmd, chgCmd} != pinState_reg && age_reg != 2'h0) begin
            pinState_reg <= {ext1Cmd, ext0Cmd, chgCmd};
            age_reg <= 2'h0;
        end else if (age_reg != 2'h3) begin
            age_reg <= age_reg + 2'h1;
        end
    end
endmodule : eivu_pin_model
`default_nettype wire

// File: bench/tb_ext_interrupt_vector_unit.sv
// Self-checking bench of the external interrupt and vector unit.
`timescale 1ns/1ps
`default_nettype none
module tb_ext_interrupt_vector_unit;
    logic sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, e, extReq0Pin, extReq1Pin, irqReq, wakeUp, resumeNext;
    logic ext0Cmd = 1'b1, ext1Cmd = 1'b1, globalEnable = 1'b1, sleeping = 1'b0;
    logic ioClkRun = 1'b1, coreAck = 1'b0;
    logic [15:0] chgCmd = 16'hFFFF, changeWatchPins;
    logic [17:0] periphReq = 18'h0;
    logic [4:0] vecAddr;
    int err_total = 0, checks = 0, seed = 2231, cyc = 0;
    eivu_pin_model u_pins (.sys_clk, .ext0Cmd, .ext1Cmd, .chgCmd, .extReq0Pin, .extReq1Pin,
        .changeWatchPins);
    eivu_top #(.STARTUP_CYC(12)) u_dut (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .extReq0Pin, .extReq1Pin, .changeWatchPins,
        .periphReq, .globalEnable, .sleeping, .ioClkRun, .startupFuse(2'h0),
        .clockSourceFuse(4'h0), .coreAck, .irqReq, .vecAddr, .wakeUp, .resumeNext);
    always #12.5 sys_clk = ~sys_clk;
    task automatic tally_and_finish;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask : wr
    task automatic rdc(input logic [7:0] idx, input logic [31:0] x);
        apb(1'b0, idx, 32'h0);
        chk("prdata", rd, x);
    endtask : rdc
    task automatic waitIrq(input logic [4:0] v);
        for (int n = 0; n < 40 && irqReq !== 1'b1; n++) @(posedge sys_clk);
        chk("irqVec", 32'({irqReq, vecAddr}), 32'({1'b1, v}));
    endtask : waitIrq
    task automatic ack;
        coreAck <= 1'b1;
        @(posedge sys_clk);
        coreAck <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask : ack
    // Lowest enabled source wins; slots of the pin requests are not peripheral inputs.
    function automatic logic [4:0] expVec(input logic [17:0] r);
        for (int i = 0; i < 18; i++) if (r[i] && i != 0 && i != 1 && i != 12) return 5'(i + 1);
        return 5'h00;
    endfunction : expVec
    initial begin
        logic [17:0] r;
        logic [1:0] m;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        chk("vecAddr", 32'(vecAddr), 32'(eivu_pkg::VEC_RESET));
        rdc(eivu_pkg::IDX_CORE_CTRL, 32'h0);
        rdc(eivu_pkg::IDX_GEN_MASK, 32'h0);
        rdc(eivu_pkg::IDX_GEN_FLAG, 32'h0);
        rdc(eivu_pkg::IDX_CHG_MASK_A, 32'(eivu_pkg::CHG_MASK_A_RST));
        rdc(eivu_pkg::IDX_CHG_MASK_B, 32'(eivu_pkg::CHG_MASK_B_RST));
        apb(1'b0, 8'h01, 32'h0);
        chk("pslverr", 32'(e), 32'h1);
        for (int i = 0; i < 12; i++) begin
            r = (i == 0) ? 18'h00004 : (i == 1) ? 18'h01003 : 18'($random(seed));
            r[17] = 1'b1;
            periphReq <= r;
            repeat (4) @(posedge sys_clk);
            chk("periphVec", 32'({irqReq, vecAddr}), 32'({1'b1, expVec(r)}));
        end
        periphReq <= 18'h0;
        wr(eivu_pkg::IDX_GEN_MASK, 32'h40);
        for (int i = 0; i < 3; i++) begin
            m = (i == 0) ? eivu_pkg::EIVU_SENSE_FALL : (i == 1) ? eivu_pkg::EIVU_SENSE_RISE
                : eivu_pkg::EIVU_SENSE_ANY;
            wr(eivu_pkg::IDX_CORE_CTRL, 32'(m));
            ext0Cmd <= (i == 1);
            waitIrq(eivu_pkg::VEC_EXT0);
            ack();
            chk("irqReq", 32'(irqReq), 32'h0);
        end
        wr(eivu_pkg::IDX_CORE_CTRL, 32'(eivu_pkg::EIVU_SENSE_LOW));
        waitIrq(eivu_pkg::VEC_EXT0);
        ack();
        repeat (3) @(posedge sys_clk);
        chk("irqReq", 32'(irqReq), 32'h1);
        rdc(eivu_pkg::IDX_GEN_FLAG, 32'h0);
        ext0Cmd <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk("irqReq", 32'(irqReq), 32'h0);
        wr(eivu_pkg::IDX_CORE_CTRL, 32'(eivu_pkg::EIVU_SENSE_FALL));
        wr(eivu_pkg::IDX_GEN_MASK, 32'h80);
        ext1Cmd <= 1'b0;
        waitIrq(eivu_pkg::VEC_EXT1);
        ack();
        ext1Cmd <= 1'b1;
        repeat (6) @(posedge sys_clk);
        ioClkRun <= 1'b0;
        ext1Cmd <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk("irqReq", 32'(irqReq), 32'h0);
        ext1Cmd <= 1'b1;
        repeat (8) @(posedge sys_clk);
        ioClkRun <= 1'b1;
        wr(eivu_pkg::IDX_GEN_MASK, 32'h20);
        chgCmd <= 16'hFFFB;
        repeat (10) @(posedge sys_clk);
        chk("irqReq", 32'(irqReq), 32'h0);
        for (int i = 0; i < 2; i++) begin
            chgCmd[3] <= i[0];
            waitIrq(eivu_pkg::VEC_PC);
            ack();
        end
        globalEnable <= 1'b0;
        wr(eivu_pkg::IDX_GEN_MASK, 32'h40);
        ext0Cmd <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk("irqReq", 32'(irqReq), 32'h0);
        rdc(eivu_pkg::IDX_GEN_FLAG, 32'h40);
        wr(eivu_pkg::IDX_GEN_FLAG, 32'h40);
        rdc(eivu_pkg::IDX_GEN_FLAG, 32'h0);
        ext0Cmd <= 1'b1;
        globalEnable <= 1'b1;
        wr(eivu_pkg::IDX_CORE_CTRL, 32'(eivu_pkg::EIVU_SENSE_LOW));
        // First pass lets go early; the second holds the level through start-up.
        for (int i = 0; i < 2; i++) begin
            sleeping <= 1'b1;
            ext0Cmd <= 1'b0;
            for (int n = 0; n < 30 && wakeUp !== 1'b1; n++) @(posedge sys_clk);
            chk("wakeUp", 32'(wakeUp), 32'h1);
            sleeping <= 1'b0;
            ext0Cmd <= (i == 0);
            if (i == 0) begin
                for (int n = 0; n < 60 && resumeNext !== 1'b1; n++) @(posedge sys_clk);
                chk("resumeNext", 32'({resumeNext, irqReq}), 32'h2);
            end else begin
                waitIrq(eivu_pkg::VEC_EXT0);
            end
        end
        tally_and_finish();
    end
endmodule : tb_ext_interrupt_vector_unit
`default_nettype wire
